/* File: design/smcs_scanner.sv */
/*
 Sensor matrix change scanner: scans a 16 x 8 matrix, encodes each
 changed sensor into a change word, buffers words in a circular FIFO
 and hands them to the master through the host read buffer.
 Assumes an external 4-to-16 row decoder, pulled-up column returns and
 an AXI4-Lite master on the register side.
*/
// Operation
// - Column counter stays zero unless inspecting row
// - Coordinate combines row count and column count
// - XOR returns with stored row; nonzero means change
// - Reset clears status, reads baseline matrix first
// - Reset pointers after last row, else select next
// - FIFO full: wait flag clear, move word out
// - Next row if empty or buffer occupied
// - Preset counter eight, shift, decrement, test top
// - Change word: present state on top, coordinate below
// - Manage FIFO between every bit test
// - Circular FIFO, pointers advance and wrap
// - FIFO holds forty byte entries
// - Full FIFO and occupied buffer halt scanning
// - Loading host buffer sets flag until read
// - Full pin mirrors flag; not-empty pin per pass
// - No debounce; configurable scan interval instead
// - Unchanged row checks buffer and FIFO first
// - Not-empty status while the FIFO holds words
// - Sixteen rows by eight columns via decoder
// - Selected row low; high return means open
`timescale 1ns/1ps
`default_nettype none

module smcs_scanner
    import smcs_pkg::*;
#(
    parameter int DEPTH         = smcs_pkg::FIFO_DEPTH,
    parameter int INTERVAL_INIT = smcs_pkg::SCAN_INTERVAL_CYCLES
) (
    // Clock and reset
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    // AXI4-Lite write address
    input  wire logic [smcs_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                       s_axi_awprot,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [smcs_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [smcs_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                       s_axi_arprot,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    // AXI4-Lite read data
    output logic [smcs_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    // Matrix pins
    output logic [smcs_pkg::ROW_W-1:0]            row_select,
    input  wire logic [smcs_pkg::COLS-1:0]        column_return,
    // Interrupt pins to the master
    output logic                                  output_full_pin,
    output logic                                  fifo_not_empty_pin
);
    import smcs_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_TOP  = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(ROWS - 1);
    localparam logic [2:0]       SETTLE_LAST = 3'(SETTLE_CYCLES - 1);
    localparam logic [3:0]       COL_START   = 4'(COL_PRESET);

    typedef struct packed {
        smcs_state_type                 st;
        logic [ROW_W-1:0]               row;
        logic [3:0]                     col_count;
        logic [COLS-1:0]                result;
        logic [COLS-1:0]                present;
        logic [7:0]                     word_store;
        logic [2:0]                     settle;
        logic [31:0]                    wait_cnt;
        logic [ROWS-1:0][COLS-1:0]      map;
        logic [DEPTH-1:0][7:0]          fifo;
        logic [PTR_W-1:0]               in_ptr;
        logic [PTR_W-1:0]               out_ptr;
        logic [CNT_W-1:0]               count;
        logic [7:0]                     host_read_buffer;
        logic                           output_full_flag;
        logic                           nempty_pin;
        logic                           halted;
        logic                           enable;
        logic [31:0]                    interval;
        logic                           aw_hold;
        logic [AXI_ADDR_W-1:0]          aw_addr;
        logic                           w_hold;
        logic [AXI_DATA_W-1:0]          w_data;
        logic [3:0]                     w_strb;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           rvalid;
        logic [1:0]                     rresp;
        logic [AXI_DATA_W-1:0]          rdata;
    } smcs_regs_type;

    smcs_regs_type    s;
    smcs_regs_type    next_s;
    logic [COLS-1:0]  cols;
    logic [COLS-1:0]  diff;
    logic [COL_W-1:0] col_idx;
    logic [7:0]       change_word;
    logic             fifo_full;
    logic             fifo_empty;
    logic             move_word;
    logic             host_pop;
    logic [AXI_DATA_W-1:0] status_word;

    // Column returns cross into the clock domain
    smcs_input_sync #(
        .WIDTH     (COLS)
    ) u_col_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_in    (column_return),
        .level_out (cols)
    );

    // Derived views of the current state
    assign fifo_full  = (s.count == CNT_FULL);
    assign fifo_empty = (s.count == '0);
    assign diff       = cols ^ s.map[s.row];
    assign col_idx    = 3'(s.col_count - 4'h1);
    assign change_word = {s.present[col_idx], s.row, col_idx};

    // Status word seen by the master
    always_comb begin
        status_word = '0;
        status_word[STAT_FULL_BIT]   = s.output_full_flag;
        status_word[STAT_NEMPTY_BIT] = !fifo_empty;
        status_word[STAT_HALTED_BIT] = s.halted;
        status_word[STAT_COUNT_LSB +: CNT_W] = s.count;
    end

    // Bus slave, scanner and FIFO next-state logic
    always_comb begin
        next_s    = s;
        move_word = 1'b0;
        host_pop  = 1'b0;

        // Write address and data are taken independently
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_hold = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_hold = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end

        // Write once both halves are held
        if (s.aw_hold && s.w_hold) begin
            next_s.aw_hold = 1'b0;
            next_s.w_hold  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            if (s.aw_addr == CONTROL_OFFSET) begin
                if (s.w_strb[0]) begin
                    next_s.enable = s.w_data[CTRL_ENABLE_BIT];
                end
            end else if (s.aw_addr == INTERVAL_OFFSET) begin
                for (int i = 0; i < 4; i++) begin
                    if (s.w_strb[i]) begin
                        next_s.interval[8*i +: 8] = s.w_data[8*i +: 8];
                    end
                end
            end else if (s.aw_addr == STATUS_OFFSET) begin
                next_s.bresp = RESP_OKAY;             // Read-only, ignored
            end else if (s.aw_addr == HOST_BUFFER_OFFSET) begin
                next_s.bresp = RESP_OKAY;             // Read-only, ignored
            end else begin
                next_s.bresp = RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Read decode; reading the host buffer empties it
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            next_s.rdata  = '0;
            if (s_axi_araddr == STATUS_OFFSET) begin
                next_s.rdata = status_word;
            end else if (s_axi_araddr == HOST_BUFFER_OFFSET) begin
                next_s.rdata[7:0] = s.host_read_buffer;
                host_pop = 1'b1;
            end else if (s_axi_araddr == CONTROL_OFFSET) begin
                next_s.rdata[CTRL_ENABLE_BIT] = s.enable;
            end else if (s_axi_araddr == INTERVAL_OFFSET) begin
                next_s.rdata = s.interval;
            end else begin
                next_s.rresp = RESP_SLVERR;
            end
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        // Master read clears the flag; a load wins
        if (host_pop) begin
            next_s.output_full_flag = 1'b0;
        end

        case (s.st)
            // Capture the baseline image one row at a time
            ST_BASELINE: begin
                if (s.settle != SETTLE_LAST) begin
                    next_s.settle = s.settle + 3'h1;
                end else begin
                    next_s.settle     = '0;
                    next_s.map[s.row] = cols;
                    if (s.row == ROW_LAST) begin
                        next_s.row = '0;
                        next_s.st  = ST_SELECT;
                    end else begin
                        next_s.row = s.row + 4'h1;
                    end
                end
            end

            // Row address out; wait for returns, then compare
            ST_SELECT: begin
                if (s.settle != SETTLE_LAST) begin
                    next_s.settle = s.settle + 3'h1;
                end else begin
                    next_s.settle  = '0;
                    next_s.present = cols;
                    next_s.st      = ST_MANAGE;
                    if (diff == '0) begin
                        next_s.col_count = '0;
                    end else begin
                        next_s.result    = diff;
                        next_s.col_count = COL_START;
                    end
                end
            end

            // One shift, test and encode of the compare result
            ST_ENCODE: begin
                next_s.col_count = s.col_count - 4'h1;
                next_s.result    = {s.result[COLS-2:0], 1'b0};
                if (s.result[COLS-1]) begin
                    next_s.word_store      = change_word;
                    next_s.fifo[s.in_ptr]  = change_word;
                    next_s.in_ptr = (s.in_ptr == PTR_TOP) ? '0
                                  : s.in_ptr + PTR_W'(1);
                    next_s.count  = s.count + CNT_W'(1);
                end
                next_s.st = ST_MANAGE;
            end

            // FIFO and host buffer upkeep between every step
            ST_MANAGE: begin
                next_s.nempty_pin = !fifo_empty;
                next_s.halted     = 1'b0;
                if (fifo_full) begin
                    if (!s.output_full_flag) begin
                        move_word = 1'b1;
                    end else begin
                        next_s.halted = 1'b1;
                    end
                end else if (s.col_count != '0) begin
                    next_s.st = ST_ENCODE;
                end else if (fifo_empty || s.output_full_flag) begin
                    next_s.map[s.row] = s.present;
                    next_s.col_count  = '0;
                    if (s.row == ROW_LAST) begin
                        next_s.row      = '0;
                        next_s.wait_cnt = '0;
                        next_s.st       = ST_INTERVAL;
                    end else begin
                        next_s.row = s.row + 4'h1;
                        next_s.st  = ST_SELECT;
                    end
                end else begin
                    move_word = 1'b1;
                end
            end

            // Scan interval covers bounce and sets the scan rate
            ST_INTERVAL: begin
                if (s.wait_cnt < s.interval) begin
                    next_s.wait_cnt = s.wait_cnt + 32'h1;
                end else if (s.enable) begin
                    next_s.st = ST_SELECT;
                end
            end

            default: begin
                next_s.st = ST_BASELINE;
            end
        endcase

        // Oldest word moves into the host read buffer
        if (move_word) begin
            next_s.host_read_buffer = s.fifo[s.out_ptr];
            next_s.output_full_flag = 1'b1;
            next_s.out_ptr = (s.out_ptr == PTR_TOP) ? '0
                           : s.out_ptr + PTR_W'(1);
            next_s.count   = s.count - CNT_W'(1);
        end
    end

    // State register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s          <= '0;
            s.enable   <= CTRL_ENABLE_RESET;
            s.interval <= 32'(INTERVAL_INIT);
        end else begin
            s <= next_s;
        end
    end

    // Bus handshakes
    assign s_axi_awready = !s.aw_hold && !s.bvalid;
    assign s_axi_wready  = !s.w_hold && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rresp   = s.rresp;
    assign s_axi_rdata   = s.rdata;

    // Pins; the external decoder pulls the addressed row low
    assign row_select         = s.row;
    assign output_full_pin    = s.output_full_flag;
    assign fifo_not_empty_pin = s.nempty_pin;

endmodule // smcs_scanner

`default_nettype wire

/* File: design/smcs_pkg.sv */
/*
 Shared constants of the sensor matrix change scanner: register map,
 status field positions, matrix and FIFO sizes, scan timing.
 Assumes a 20 MHz device clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package smcs_pkg;

    // Bus widths
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] STATUS_OFFSET      = 8'h00;
    localparam logic [7:0] HOST_BUFFER_OFFSET = 8'h04;
    localparam logic [7:0] CONTROL_OFFSET     = 8'h08;
    localparam logic [7:0] INTERVAL_OFFSET    = 8'h0C;

    // Status field positions
    localparam int STAT_FULL_BIT   = 0;
    localparam int STAT_NEMPTY_BIT = 1;
    localparam int STAT_HALTED_BIT = 2;
    localparam int STAT_COUNT_LSB  = 8;

    // Control field positions and reset values
    localparam int   CTRL_ENABLE_BIT   = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Matrix geometry
    localparam int ROWS       = 16;
    localparam int COLS       = 8;
    localparam int ROW_W      = 4;
    localparam int COL_W      = 3;
    localparam int COL_PRESET = 8;

    // Change word FIFO depth
    localparam int FIFO_DEPTH = 40;

    // Cycles from a row change to a usable column sample
    localparam int SETTLE_CYCLES = 6;

    // Scan interval timing
    localparam int CLOCK_MHZ        = 20;
    localparam int SCAN_INTERVAL_US = 2000;
    localparam int SCAN_INTERVAL_CYCLES = SCAN_INTERVAL_US * CLOCK_MHZ;

    // Scanner states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ST_BASELINE = 3'h0,
        ST_SELECT   = 3'h1,
        ST_MANAGE   = 3'h3,
        ST_ENCODE   = 3'h2,
        ST_INTERVAL = 3'h6
    } smcs_state_type;

endpackage : smcs_pkg

`default_nettype wire

/* File: design/smcs_input_sync.sv */
/*
 Three-stage synchroniser for the column return pins.
 Assumes asynchronous pin inputs; an output bit follows its pin once
 the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none

module smcs_input_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Pin side
    input  wire logic [WIDTH-1:0] pin_in,
    // Filtered level
    output logic      [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] level;
    } smcs_sync_type;

    smcs_sync_type s;
    smcs_sync_type next_s;
    logic [WIDTH-1:0] agree;

    // Shift chain; a bit updates only where stages two and three agree
    always_comb begin
        next_s        = s;
        agree         = ~(s.stage2 ^ s.stage3);
        next_s.stage1 = pin_in;
        next_s.stage2 = s.stage1;
        next_s.stage3 = s.stage2;
        next_s.level  = (agree & s.stage3) | (~agree & s.level);
    end

    // State register, columns idle high (open)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign level_out = s.level;

endmodule // smcs_input_sync

`default_nettype wire

/* File: testbench/smcs_matrix_model.sv */
/*
 Sensor matrix model: row decoder, switches and pulled-up returns.
 Assumes one closed bit per sensor at index row*8+column.
*/
`timescale 1ns/1ps
`default_nettype none
module smcs_matrix_model (
    // Row address in, column returns out
    input  wire logic [smcs_pkg::ROW_W-1:0] row_select,
    output logic      [smcs_pkg::COLS-1:0]  column_return,
    // Switch states, 1 = closed
    input  wire logic [127:0]               closed
);
    // Addressed row is low, so a closed switch pulls its column low
    assign column_return = ~closed[row_select*8 +: 8];
endmodule // smcs_matrix_model
`default_nettype wire

/* File: testbench/smcs_scanner_asserts.sv */
/*
 Checker for smcs_scanner ports, bound to every instance.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module smcs_scanner_asserts
    import smcs_pkg::*;
(
    // Clock and reset
    input wire logic                       aclk,
    input wire logic                       aresetn,
    // Bus handshakes
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_bready,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    // Matrix and interrupt pins
    input wire logic [smcs_pkg::ROW_W-1:0] row_select,
    input wire logic                       output_full_pin,
    input wire logic                       fifo_not_empty_pin
);
    logic buf_read;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A read was taken since the full pin last rose
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_read <= 1'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            buf_read <= 1'h1;
        end else if ($rose(output_full_pin)) begin
            buf_read <= 1'h0;
        end
    end

    // Handshake steps
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    row_step_a: assert property (
        $changed(row_select) |-> row_select == $past(row_select) + 4'h1)
        else $error("row select skipped a row");
    row_hold_a: assert property (
        $changed(row_select) |=> $stable(row_select) [*5])
        else $error("row select left too early");
    init_state_a: assert property (
        $rose(aresetn) |-> row_select == 4'h0 && !output_full_pin
            && !fifo_not_empty_pin)
        else $error("outputs not cleared by reset");
    full_clear_a: assert property (
        $fell(output_full_pin) |-> buf_read)
        else $error("full pin fell without a read");
    nempty_load_a: assert property (
        fifo_not_empty_pin |-> ##[0:300] output_full_pin)
        else $error("queued word never reached host buffer");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    wr_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    wr_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule // smcs_scanner_asserts

bind smcs_scanner smcs_scanner_asserts u_asserts (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .row_select,
    .output_full_pin, .fifo_not_empty_pin);
`default_nettype wire

/* File: testbench/test_sensor_matrix_change_scanner.sv */
/*
 Self-checking bench: AXI4-Lite master, matrix model, word model.
 Assumes the scanner parks in its interval state while disabled.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sensor_matrix_change_scanner;
    import smcs_pkg::*;
    localparam int FDEPTH = 4;
    logic         aclk          = 1'h0;
    logic         aresetn       = 1'h0;
    logic [7:0]   s_axi_awaddr  = '0;
    logic [7:0]   s_axi_araddr  = '0;
    logic [31:0]  s_axi_wdata   = '0;
    logic         s_axi_awvalid = 1'h0;
    logic         s_axi_wvalid  = 1'h0;
    logic         s_axi_bready  = 1'h0;
    logic         s_axi_arvalid = 1'h0;
    logic         s_axi_rready  = 1'h0;
    logic [127:0] closed        = '0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic         s_axi_arready, s_axi_rvalid;
    logic         output_full_pin, fifo_not_empty_pin;
    logic [31:0]  s_axi_rdata;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic [3:0]   row_select;
    logic [7:0]   column_return;
    logic [7:0]   expq[$];
    int           bad_count     = 0;
    int           comparisons   = 0;

    // 20 MHz clock
    always #25 aclk = ~aclk;

    smcs_scanner #(.DEPTH(FDEPTH), .INTERVAL_INIT(20)) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .row_select, .column_return, .output_full_pin,
        .fifo_not_empty_pin);
    smcs_matrix_model u_matrix (.row_select, .column_return, .closed);

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // Counts, verdict, end of run
    task automatic results();
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One bus transfer; handshakes seen at the falling edge
    task automatic bus(input bit w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic [1:0] r);
        bit ta, tw, tr, done;
        int n;
        done = 0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_bready  <= w;
        s_axi_arvalid <= !w;
        s_axi_rready  <= !w;
        while (!done && n < 100) begin
            @(negedge aclk);
            n++;
            ta = (s_axi_awvalid && s_axi_awready)
                 || (s_axi_arvalid && s_axi_arready);
            tw = s_axi_wvalid && s_axi_wready;
            tr = w ? s_axi_bvalid : s_axi_rvalid;
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (tw) s_axi_wvalid <= 1'h0;
            if (tr) begin
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                done = 1;
            end
        end
        if (!done) begin
            bad_count++;
            results();
        end
    endtask

    // Queue words a new switch image must produce
    task automatic apply(input logic [127:0] nw);
        logic [7:0] x;
        for (int r = 0; r < 16; r++) begin
            x = closed[r*8 +: 8] ^ nw[r*8 +: 8];
            for (int c = 7; c >= 0; c--) begin
                if (x[c]) expq.push_back({~nw[r*8+c], r[3:0], c[2:0]});
            end
        end
        closed <= nw;
    endtask

    function automatic logic [127:0] flip(input logic [127:0] v);
        repeat (3) v[$urandom_range(127, 0)] ^= 1'h1;
        return v;
    endfunction

    // Poll for each word and compare in order
    task automatic drain();
        logic [31:0] q;
        logic [1:0]  r;
        int          n;
        while (expq.size() > 0) begin
            q = '0;
            for (n = 0; n < 3000 && !q[STAT_FULL_BIT]; n++) begin
                bus(1'h0, STATUS_OFFSET, '0, q, r);
            end
            check(q[STAT_FULL_BIT], 1'h1);
            if (!q[STAT_FULL_BIT]) results();
            bus(1'h0, HOST_BUFFER_OFFSET, '0, q, r);
            check(q[7:0], expq.pop_front());
        end
    endtask

    // Park, change switches, rescan, collect
    task automatic round(input logic [127:0] nw, input bit halt);
        logic [31:0] q;
        logic [1:0]  r;
        logic [3:0]  rs;
        bus(1'h1, CONTROL_OFFSET, '0, q, r);
        repeat (600) @(posedge aclk);
        apply(nw);
        bus(1'h1, CONTROL_OFFSET, 32'h1, q, r);
        if (halt) begin
            repeat (600) @(posedge aclk);
            bus(1'h0, STATUS_OFFSET, '0, q, r);
            check(q & 32'h7F07, FDEPTH << 8 | 7);
            @(negedge aclk);
            rs = row_select;
            check({output_full_pin, fifo_not_empty_pin}, 2'h3);
            repeat (50) @(negedge aclk);
            check(row_select, rs);
        end
        drain();
        repeat (300) @(posedge aclk);
        bus(1'h0, STATUS_OFFSET, '0, q, r);
        check(q & 32'h7F07, '0);
        check({output_full_pin, fifo_not_empty_pin}, '0);
    endtask

    // Main sequence
    initial begin
        logic [31:0] q;
        logic [1:0]  r;
        void'($urandom(36515));
        closed = {$urandom(), $urandom(), $urandom(), $urandom()};
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        bus(1'h0, STATUS_OFFSET, '0, q, r);
        check(q, '0);
        bus(1'h0, CONTROL_OFFSET, '0, q, r);
        check(q[0], CTRL_ENABLE_RESET);
        bus(1'h0, INTERVAL_OFFSET, '0, q, r);
        check(q, 32'h14);
        bus(1'h1, INTERVAL_OFFSET, 32'h32, q, r);
        bus(1'h0, INTERVAL_OFFSET, '0, q, r);
        check(q, 32'h32);
        bus(1'h1, STATUS_OFFSET, 32'hFF, q, r);
        check(r, RESP_OKAY);
        bus(1'h0, 8'h10, '0, q, r);
        check(q, '0);
        check(r, RESP_SLVERR);
        bus(1'h1, 8'h10, 32'h1, q, r);
        check(r, RESP_SLVERR);
        for (int k = 0; k < 7; k++) begin
            round(k == 3 ? closed ^ (128'hFF << 40) : flip(closed), k == 3);
        end
        // Reset with words pending clears status
        apply(closed ^ 128'hFF);
        repeat (600) @(posedge aclk);
        aresetn <= 1'h0;
        expq.delete();
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        bus(1'h0, STATUS_OFFSET, '0, q, r);
        check(q, '0);
        round(flip(closed), 1'h0);
        results();
    end
endmodule // test_sensor_matrix_change_scanner
`default_nettype wire
